// ===== design/ebsw_pkg.sv
// Purpose: Shared constants for the external bus strobe and wait-state block
// Assumes: Core clock 125 MHz, also driven out as the bus clock
// Notes:   Wait count width and reset value live here
package ebsw_pkg;

   localparam int          WAIT_W         = 4;
   localparam logic [3:0]  WAIT_RST       = 4'h0;
   localparam int          CLK_MHZ        = 125;
   localparam int          SYNC_MAX_MHZ   = 100;
   localparam logic        ACK_ASSERTED   = 1'b0;
   localparam logic        STROBE_IDLE    = 1'b1;
   localparam logic        STROBE_ACTIVE  = 1'b0;

   typedef enum logic [1:0]
   {
      EBSW_IDLE = 2'b00,
      EBSW_WAIT = 2'b01,
      EBSW_ACK  = 2'b10,
      EBSW_DONE = 2'b11
   } ebsw_state_t;

endpackage

// ===== design/ebsw_ack_sync.sv
// Purpose: Two-stage synchroniser for the acknowledge pin
// Assumes: Single clock domain on the sampling side
// Notes:   Stage one is read only by stage two
`timescale 1ns/1ps
module ebsw_ack_sync
   import ebsw_pkg::*;
(
   input  wire logic clk_sys_i,
   input  wire logic rstn_i,
   input  wire logic async_i,
   output logic      sync_o
);

   logic meta_r;
   logic meta_nxt;
   logic sync_r;
   logic sync_nxt;

   always_comb
   begin
      meta_nxt = async_i;
      sync_nxt = meta_r;
   end

   // Idle level is deasserted (high)
   always_ff @(posedge clk_sys_i)
   begin
      if (!rstn_i)
      begin
         meta_r <= 1'b1;
         sync_r <= 1'b1;
      end
      else
      begin
         meta_r <= meta_nxt;
         sync_r <= sync_nxt;
      end
   end

   assign sync_o = sync_r;

endmodule

// ===== design/ebsw_ctrl.sv
// Purpose: Read/write strobes and wait-state stretching for an external bus
// Assumes: Core starts cycles by a one-cycle request pulse; bus mastership given
// Notes:   Strobe pins are tri-statable: out value plus output enable
`timescale 1ns/1ps

module ebsw_ctrl
   import ebsw_pkg::*;
#(
   parameter int WAIT_BITS = WAIT_W
)
(
   input  wire logic                 clk_sys_i,
   input  wire logic                 rstn_i,
   input  wire logic                 bus_master_i,
   input  wire logic                 cyc_req_i,
   input  wire logic                 cyc_write_i,
   input  wire logic [WAIT_BITS-1:0] bus_wait_config_i,
   input  wire logic                 ack_sync_select_i,
   input  wire logic                 transfer_acknowledge_n_i,
   output logic                      bus_clock_output_o,
   output logic                      rd_n_o,
   output logic                      rd_n_oe_o,
   output logic                      wr_n_o,
   output logic                      wr_n_oe_o,
   output logic                      cyc_busy_o,
   output logic                      cyc_done_o
);

   // Elaboration guard: the countdown needs a usable width
   generate
      if (WAIT_BITS < 1 || WAIT_BITS > 16)
      begin : g_bad_wait_bits
         $error("WAIT_BITS out of range");
      end
   endgenerate

   // ----------------------------------------
   // Acknowledge sampling
   // ----------------------------------------
   logic ack_sync;
   logic ack_direct_r;
   logic ack_seen_n;

   ebsw_ack_sync u_sync
   (
      .clk_sys_i (clk_sys_i),
      .rstn_i    (rstn_i),
      .async_i   (transfer_acknowledge_n_i),
      .sync_o    (ack_sync)
   );

   // Direct mode still registers once; pin is assumed bus-clock aligned
   always_ff @(posedge clk_sys_i)
   begin
      if (!rstn_i)
         ack_direct_r <= 1'b1;
      else
         ack_direct_r <= transfer_acknowledge_n_i;
   end

   assign ack_seen_n = ack_sync_select_i ? ack_sync : ack_direct_r;

   // ----------------------------------------
   // Cycle state
   // ----------------------------------------
   ebsw_state_t          state_r;
   ebsw_state_t          state_nxt;
   logic [WAIT_BITS-1:0] cnt_r;
   logic [WAIT_BITS-1:0] cnt_nxt;
   logic                 write_r;
   logic                 write_nxt;
   logic                 zero_r;
   logic                 zero_nxt;

   always_comb
   begin
      state_nxt = state_r;
      cnt_nxt   = cnt_r;
      write_nxt = write_r;
      zero_nxt  = zero_r;
      case (state_r)
         EBSW_IDLE:
         begin
            if (cyc_req_i && bus_master_i)
            begin
               write_nxt = cyc_write_i;
               cnt_nxt   = bus_wait_config_i;
               zero_nxt  = (bus_wait_config_i == '0);
               state_nxt = EBSW_WAIT;
            end
         end
         EBSW_WAIT:
         begin
            if (cnt_r != '0)
               cnt_nxt = cnt_r - 1'b1;
            else if (zero_r)
               state_nxt = EBSW_DONE;
            else if (ack_seen_n == ACK_ASSERTED)
               state_nxt = EBSW_ACK;
         end
         EBSW_ACK:
         begin
            // finish one clock after acknowledge seen
            state_nxt = EBSW_DONE;
         end
         EBSW_DONE:
         begin
            state_nxt = EBSW_IDLE;
         end
         default:
         begin
            state_nxt = EBSW_IDLE;
         end
      endcase
      if (!bus_master_i && state_r == EBSW_IDLE)
         state_nxt = EBSW_IDLE;
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (!rstn_i)
      begin
         state_r <= EBSW_IDLE;
         cnt_r   <= '0;
         write_r <= 1'b0;
         zero_r  <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         cnt_r   <= cnt_nxt;
         write_r <= write_nxt;
         zero_r  <= zero_nxt;
      end
   end

   // ----------------------------------------
   // Strobes
   // ----------------------------------------
   logic rd_r;
   logic rd_nxt;
   logic wr_r;
   logic wr_nxt;
   logic oe_r;
   logic oe_nxt;
   logic act_nxt;

   always_comb
   begin
      act_nxt = (state_nxt == EBSW_WAIT) || (state_nxt == EBSW_ACK);
      rd_nxt  = (act_nxt && !write_nxt) ? STROBE_ACTIVE : STROBE_IDLE;
      wr_nxt  = (act_nxt && write_nxt) ? STROBE_ACTIVE : STROBE_IDLE;
      oe_nxt  = bus_master_i;
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (!rstn_i)
      begin
         rd_r <= STROBE_IDLE;
         wr_r <= STROBE_IDLE;
         oe_r <= 1'b0;
      end
      else
      begin
         rd_r <= rd_nxt;
         wr_r <= wr_nxt;
         oe_r <= oe_nxt;
      end
   end

   assign rd_n_o             = rd_r;
   assign wr_n_o             = wr_r;
   assign rd_n_oe_o          = oe_r;
   assign wr_n_oe_o          = oe_r;
   assign cyc_busy_o         = (state_r != EBSW_IDLE);
   assign cyc_done_o         = (state_r == EBSW_DONE);
   // Core clock forwarded as the bus clock
   assign bus_clock_output_o = clk_sys_i;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   a_rd_released: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      !$past(bus_master_i) |-> !rd_n_oe_o)
      else $error("read strobe driven while not master");

   a_rd_low_read: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      (rd_n_o == STROBE_ACTIVE) |-> !write_r && cyc_busy_o)
      else $error("read strobe low outside a read");

   a_wr_low_write: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      (wr_n_o == STROBE_ACTIVE) |-> write_r && cyc_busy_o)
      else $error("write strobe low outside a write");

   a_idle_ignore_ack: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      (state_r == EBSW_IDLE && !cyc_req_i) |=> state_r == EBSW_IDLE)
      else $error("cycle started without request");

   a_stretch_hold: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      (state_r == EBSW_WAIT && cnt_r == '0 && !zero_r && ack_seen_n) |=> state_r == EBSW_WAIT)
      else $error("cycle ended with acknowledge off");

   a_min_waits: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      (state_r == EBSW_WAIT && cnt_r != '0) |=> state_r == EBSW_WAIT && cnt_r == $past(cnt_r) - 1'b1)
      else $error("programmed waits not honoured");

   a_zero_wait: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      (state_r == EBSW_IDLE && cyc_req_i && bus_master_i && bus_wait_config_i == '0)
      |=> state_r == EBSW_WAIT ##1 state_r == EBSW_DONE)
      else $error("zero-wait access stretched");

   a_ack_finish: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      (state_r == EBSW_WAIT && cnt_r == '0 && !zero_r && !ack_seen_n)
      |=> state_r == EBSW_ACK ##1 cyc_done_o ##1 !cyc_busy_o)
      else $error("cycle not finished one clock after acknowledge");

   a_sync_path: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      ack_sync_select_i && $stable(ack_sync_select_i) |-> ack_seen_n == $past(transfer_acknowledge_n_i, 2)
      || $past(!rstn_i, 2))
      else $error("synchronised acknowledge latency wrong");

   a_direct_path: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      !ack_sync_select_i |-> ack_seen_n == $past(transfer_acknowledge_n_i))
      else $error("direct acknowledge latency wrong");

endmodule

// ===== dv/ebsw_resp_model.sv
// Purpose: Responder model that drives the acknowledge pin
// Assumes: Strobes are active low and qualified by their enables
// Notes:   Async mode moves the pin half a cycle off the clock edge
`timescale 1ns/1ps
module ebsw_resp_model
(
   input  wire logic       clk_i,
   input  wire logic       rd_n_i,
   input  wire logic       rd_oe_i,
   input  wire logic       wr_n_i,
   input  wire logic       wr_oe_i,
   input  wire logic [7:0] dly_i,
   input  wire logic       stall_i,
   input  wire logic       hold_low_i,
   input  wire logic       async_i,
   output logic            ack_n_o
);
   logic [7:0] cnt_r = 8'h00;
   logic       ack_r = 1'b1;
   logic       ack_a_r = 1'b1;
   logic       act;
   assign act = (rd_oe_i && !rd_n_i) || (wr_oe_i && !wr_n_i);
   always @(posedge clk_i)
   begin
      cnt_r <= act ? cnt_r + 8'h01 : 8'h00;
      ack_r <= hold_low_i ? 1'b0 : !(act && !stall_i && cnt_r >= dly_i);
   end
   // Off-edge copy for the synchronised mode
   always @(negedge clk_i)
      ack_a_r <= ack_r;
   assign ack_n_o = async_i ? ack_a_r : ack_r;
endmodule

// ===== dv/ebsw_ctrl_bench.sv
// Purpose: Self-checking bench for the strobe and wait-state block
// Assumes: Responder model on the acknowledge pin
// Notes:   Latency is checked against a window; here every window is one figure
`timescale 1ns/1ps
module ebsw_ctrl_bench import ebsw_pkg::*;;
   typedef struct packed {logic w; logic [7:0] lo; logic [7:0] hi;} ebsw_exp_t;
   logic clk_sys_i, rstn_i, master, req, wr, sync, ack_n, stall, hold;
   logic [3:0] wcfg;
   logic [7:0] dly;
   logic rd_n, rd_oe, wr_n, wr_oe, busy, done, seen_rd, seen_wr, bclk;
   ebsw_exp_t q[$];
   ebsw_exp_t e;
   int n_errors = 0, checks = 0, seed = 32'h82e5, cyc = 0, t0 = 0, lat, n, s, d, x, lat_exp;
   ebsw_ctrl ebsw_ctrl_i (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .bus_master_i(master),
      .cyc_req_i(req), .cyc_write_i(wr), .bus_wait_config_i(wcfg), .ack_sync_select_i(sync),
      .transfer_acknowledge_n_i(ack_n), .bus_clock_output_o(bclk), .rd_n_o(rd_n), .rd_n_oe_o(rd_oe),
      .wr_n_o(wr_n), .wr_n_oe_o(wr_oe), .cyc_busy_o(busy), .cyc_done_o(done));
   ebsw_resp_model ebsw_resp_model_i (.clk_i(bclk), .rd_n_i(rd_n), .rd_oe_i(rd_oe),
      .wr_n_i(wr_n), .wr_oe_i(wr_oe), .dly_i(dly), .stall_i(stall), .hold_low_i(hold),
      .async_i(sync), .ack_n_o(ack_n));
   task check(input logic [7:0] seen, input logic [7:0] exp, input string what);
      checks++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("wrong value %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task stop_test;
      $display("errors %0d checks %0d", n_errors, checks);
      if (n_errors == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // Note the expectation, issue one cycle, wait for completion
   task run(input logic [3:0] nw, input logic w, ss, input logic [7:0] dd, input logic st,
            input logic [7:0] lo, hi);
      int k;
      q.push_back({w, lo, hi});
      @(posedge clk_sys_i);
      req <= 1'b1;
      wr <= w;
      wcfg <= nw;
      sync <= ss;
      dly <= dd;
      stall <= st;
      @(posedge clk_sys_i);
      req <= 1'b0;
      k = 0;
      while (done !== 1'b1 && k < 200)
      begin
         @(posedge clk_sys_i);
         k++;
      end
      @(posedge clk_sys_i);
   endtask
   // ----------------------------------------
   // Result watcher
   // ----------------------------------------
   always @(posedge clk_sys_i)
   begin
      cyc++;
      if (req === 1'b1 && master === 1'b1 && busy === 1'b0)
      begin
         t0 = cyc;
         seen_rd = 1'b0;
         seen_wr = 1'b0;
      end
      if (rd_n === 1'b0 && rd_oe === 1'b1) seen_rd = 1'b1;
      if (wr_n === 1'b0 && wr_oe === 1'b1) seen_wr = 1'b1;
      if (done === 1'b1)
      begin
         if (q.size() == 0)
            check(8'h01, 8'h00, "unexpected done");
         else
         begin
            e = q.pop_front();
            lat = cyc - t0;
            check({6'h00, seen_wr, seen_rd}, {6'h00, e.w, !e.w}, "strobe");
            check({7'h00, lat >= e.lo && lat <= e.hi}, 8'h01, "latency");
         end
      end
      // Ceiling far above the few hundred cycles the scenarios need
      if (cyc > 20000)
      begin
         n_errors++;
         stop_test;
      end
   end
   initial
   begin
      clk_sys_i = 1'b0;
      forever #4 clk_sys_i = ~clk_sys_i;
   end
   initial
   begin
      rstn_i = 1'b0; master = 1'b1; req = 1'b0; wr = 1'b0; wcfg = 4'h0; sync = 1'b0;
      dly = 8'h00; stall = 1'b0; hold = 1'b0;
      repeat (3) @(posedge clk_sys_i);
      check({6'h00, rd_oe, wr_oe}, 8'h00, "oe in reset");
      rstn_i <= 1'b1;
      // Direct-mode cases stand for a part clocked at or below the sync limit
      // Zero waits must not stretch on a stalled responder
      run(4'h0, 1'b1, 1'b0, 8'h00, 1'b1, 8'h02, 8'h02);
      // Long stretch by a slow responder; one programmed wait enables it
      run(4'h1, 1'b0, 1'b0, 8'h1e, 1'b0, 8'h23, 8'h23);
      // Ack low while idle and requests while not master are ignored
      hold <= 1'b1;
      master <= 1'b0;
      repeat (3) @(posedge clk_sys_i);
      req <= 1'b1;
      @(posedge clk_sys_i);
      req <= 1'b0;
      repeat (4) @(posedge clk_sys_i);
      check({7'h00, busy}, 8'h00, "busy not master");
      check({6'h00, rd_oe, wr_oe}, 8'h00, "oe not master");
      master <= 1'b1;
      repeat (2) @(posedge clk_sys_i);
      check({6'h00, rd_oe, wr_oe}, 8'h03, "oe master");
      // Ack already low: programmed minimum alone sets the length
      run(4'h2, 1'b0, 1'b0, 8'h00, 1'b0, 8'h05, 8'h05);
      run(4'h2, 1'b1, 1'b1, 8'h00, 1'b0, 8'h05, 8'h05);
      hold <= 1'b0;
      // Slow responder seen through the synchroniser: one extra edge of lag
      run(4'h2, 1'b1, 1'b1, 8'h04, 1'b0, 8'h0a, 8'h0a);
      // Random mix of directions, wait counts and responder delays, all synchronised since CLK_MHZ exceeds SYNC_MAX_MHZ
      repeat (24)
      begin
         n = 1 + ($random(seed) & 3);
         s = (CLK_MHZ > SYNC_MAX_MHZ) ? 1 : ($random(seed) & 1);
         d = $random(seed) & 7;
         x = $random(seed) & 1;
         // Countdown plus three, or ack lag (1 direct, 2 synced) plus delay plus four
         lat_exp = (n + 3 > d + 5 + s) ? n + 3 : d + 5 + s;
         run(n[3:0], x[0], s[0], d[7:0], 1'b0, lat_exp[7:0], lat_exp[7:0]);
      end
      #2 check({7'h00, bclk}, {7'h00, clk_sys_i}, "bus clock high");
      #4 check({7'h00, bclk}, {7'h00, clk_sys_i}, "bus clock low");
      // A cycle that never finished leaves its note behind
      check({7'h00, q.size() != 0}, 8'h00, "results pending");
      stop_test;
   end
endmodule
